// *** pae_defs.vh ***
// constants and register map for the process alarm evaluator
// Operation
// - analog input type codes 25..29 select 4-20mA, 0-20mA, 1-5V, 0-5V, 0-10V.
// - analog reading scaled into one of four decimal-point display ranges.
// - each channel holds type code, default 2; type 0 keeps output off.
// - separate on and off delays per alarm, 0 to 999 seconds.
// - alarm results reach auxiliary outputs through an output assignment.
// - heater variants: channel 1 is heater alarm until assigned to alarm 1.
// - type 1 alarms when value outside set point minus lower, plus upper.
// - type 2 alarms when value exceeds set point by deviation or more.
// - type 3 alarms when value below set point by deviation or more.
// - type 4 alarms when value inside the upper/lower deviation band.
// - types 5, 6, 7 equal types 1, 2, 3 plus standby sequence.
// - type 8 alarms when value above threshold, set point ignored.
// - type 9 alarms when value below threshold, set point ignored.
// - types 10, 11 equal types 8, 9 plus standby sequence.
// - type 12 loop break alarm selectable only on channel 1.
// - types 1, 4, 5 use separate upper and lower limits per channel.
`ifndef PAE_DEFS_VH
`define PAE_DEFS_VH
`define PAE_CLK_HZ 50000000
`define PAE_SEC_CYCLES (`PAE_CLK_HZ / 1)
`define PAE_DLY_MAX 10'd999
`define PAE_IN_4_20MA 5'd25
`define PAE_IN_0_20MA 5'd26
`define PAE_IN_1_5V 5'd27
`define PAE_IN_0_5V 5'd28
`define PAE_IN_0_10V 5'd29
`define PAE_TYPE_DEFAULT 5'd2
`define PAE_TYPE_MAX 5'd17
`define PAE_TYPE_LBA 5'd12
`define PAE_RAW_MAX 16'hFFFF
`define PAE_ADDR_CTRL 8'h00
`define PAE_ADDR_SP 8'h04
`define PAE_ADDR_STAT 8'h08
`define PAE_ADDR_MASK 8'h0C
`define PAE_ADDR_PV 8'h10
`define PAE_ADDR_SCALE 8'h14
`define PAE_ADDR_CH0 8'h20
`define PAE_CH_STRIDE 8'h10
`define PAE_CH_TYPE 2'd0
`define PAE_CH_HI 2'd1
`define PAE_CH_LO 2'd2
`define PAE_CH_DLY 2'd3
`define PAE_CTRL_INTYPE_LSB 0
`define PAE_CTRL_DP_LSB 8
`define PAE_CTRL_HEATER_LSB 12
`define PAE_CTRL_ASSIGN1_LSB 13
`define PAE_CTRL_RESET 32'h0000_0019
`define PAE_SCALE_RESET 32'h270F_F831
`define PAE_RESP_OKAY 2'b00
`define PAE_RESP_SLVERR 2'b10
`endif

// *** pae_alarm_evaluator.v ***
// alarm evaluation with delays, axi4-lite registers and interrupt
`timescale 1ns/100ps
`include "pae_defs.vh"
module pae_alarm_evaluator
  #(parameter SEC_CYCLES = `PAE_SEC_CYCLES)
  (
  // clock and reset
  input wire mclk,
  input wire sys_rst,
  // raw converter sample
  input wire [15:0] rawSample,
  input wire rawValid,
  // heater alarm input, external pin
  input wire heaterAlarmIn,
  // axi4-lite write
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // alarm outputs
  output reg [1:0] auxOut,
  output reg irq
  );

  localparam NCH = 2;

  // control and configuration
  reg [31:0] ctrl_r;
  reg [31:0] scale_r;
  reg signed [15:0] setPoint_r;
  reg [4:0] chType_r [0:NCH-1];
  reg signed [15:0] chHi_r [0:NCH-1];
  reg signed [15:0] chLo_r [0:NCH-1];
  reg [9:0] onDly_r [0:NCH-1];
  reg [9:0] offDly_r [0:NCH-1];
  reg [3:0] stat_r;
  reg [3:0] mask_r;
  reg signed [15:0] pv_r;
  reg pvNew_r;
  reg [1:0] heatSync_r;
  reg [1:0] armed_r;
  reg [1:0] raw_r;
  reg [1:0] alm_r;
  reg [9:0] dlyCnt_r [0:NCH-1];
  reg [25:0] secCnt_r;
  reg secTick_r;
  reg [1:0] auxNxt;

  // write channel latches; address and data may come in either order
  reg [7:0] wAddr_r;
  reg [31:0] wData_r;
  reg [3:0] wStrb_r;
  reg haveA_r;
  reg haveD_r;

  wire [4:0] inType = ctrl_r[`PAE_CTRL_INTYPE_LSB +: 5];
  wire heaterVariant = ctrl_r[`PAE_CTRL_HEATER_LSB];
  wire assign1 = ctrl_r[`PAE_CTRL_ASSIGN1_LSB];
  wire signed [15:0] scLo = scale_r[15:0];
  wire signed [15:0] scHi = scale_r[31:16];

  function [31:0] rmw;
    input [31:0] old;
    input [31:0] val;
    input [3:0] strb;
    integer k;
    begin
      rmw = old;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          rmw[k*8 +: 8] = val[k*8 +: 8];
    end
  endfunction

  function isChan;
    input [7:0] addr;
    begin
      isChan = (addr >= `PAE_ADDR_CH0) &&
        (addr < `PAE_ADDR_CH0 + `PAE_CH_STRIDE * NCH) && (addr[1:0] == 2'b00);
    end
  endfunction

  // zero-based fraction of the raw span for the live-zero inputs
  function [15:0] inOffset;
    input [4:0] t;
    begin
      case (t)
        `PAE_IN_4_20MA, `PAE_IN_1_5V: inOffset = 16'h3333;
        default: inOffset = 16'h0000;
      endcase
    end
  endfunction

  // linear scaling of raw from the live-zero offset up to ffff into [scLo, scHi]; raw below the offset reads scLo; the decimal point only moves the display
  wire [15:0] off = inOffset(inType);
  wire [15:0] span = `PAE_RAW_MAX - off;
  wire [15:0] rawAbove = (rawSample > off) ? (rawSample - off) : 16'h0000;
  wire signed [17:0] rangeW = {{2{scHi[15]}}, scHi} - {{2{scLo[15]}}, scLo};
  wire signed [34:0] prod = $signed({1'b0, rawAbove}) * rangeW;
  wire signed [34:0] quo = prod / $signed({19'h0_0000, span});
  wire signed [17:0] scaled = {{2{scLo[15]}}, scLo} + quo[17:0];

  // alarm condition for one channel
  function cond;
    input [4:0] t;
    input signed [15:0] pv;
    input signed [15:0] sp;
    input signed [15:0] hi;
    input signed [15:0] lo;
    reg signed [17:0] up;
    reg signed [17:0] dn;
    reg signed [17:0] p;
    // signed holder: a bare concatenation would turn the compare unsigned
    reg signed [17:0] dx;
    begin
      p = {{2{pv[15]}}, pv};
      up = {{2{sp[15]}}, sp} + {{2{hi[15]}}, hi};
      dn = {{2{sp[15]}}, sp} - {{2{lo[15]}}, lo};
      dx = {{2{sp[15]}}, sp} - {{2{hi[15]}}, hi};
      case (t)
        5'd1, 5'd5: cond = (p > up) || (p < dn);
        5'd2, 5'd6: cond = p >= up;
        5'd3, 5'd7: cond = p <= dx;
        5'd4: cond = (p <= up) && (p >= dn);
        5'd8, 5'd10: cond = pv > hi;
        5'd9, 5'd11: cond = pv < hi;
        default: cond = 1'b0;
      endcase
    end
  endfunction

  function hasStandby;
    input [4:0] t;
    begin
      hasStandby = (t == 5'd5) || (t == 5'd6) || (t == 5'd7) ||
        (t == 5'd10) || (t == 5'd11);
    end
  endfunction

  // sample, one-second tick, heater pin sync
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pv_r <= 16'h0000;
      pvNew_r <= 1'b0;
      secCnt_r <= 26'h000_0000;
      secTick_r <= 1'b0;
      heatSync_r <= 2'b00;
    end
    else
    begin
      heatSync_r <= {heatSync_r[0], heaterAlarmIn};
      pvNew_r <= rawValid;
      if (rawValid)
        pv_r <= scaled[15:0];
      secTick_r <= (secCnt_r == SEC_CYCLES - 1);
      if (secCnt_r == SEC_CYCLES - 1)
        secCnt_r <= 26'h000_0000;
      else
        secCnt_r <= secCnt_r + 26'h000_0001;
    end
  end

  // per-channel evaluation, standby and delays
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : ch
      wire c = cond(chType_r[g], pv_r, setPoint_r, chHi_r[g], chLo_r[g]);
      always @(posedge mclk)
      begin
        if (sys_rst)
        begin
          armed_r[g] <= 1'b0;
          raw_r[g] <= 1'b0;
          alm_r[g] <= 1'b0;
          dlyCnt_r[g] <= 10'h000;
        end
        else
        begin
          if (pvNew_r)
          begin
            if (!c)
              armed_r[g] <= 1'b1;
            raw_r[g] <= c && (!hasStandby(chType_r[g]) || armed_r[g]);
          end
          if (chType_r[g] == 5'd0)
          begin
            // a disabled channel must not keep raising its status bit
            raw_r[g] <= 1'b0;
            alm_r[g] <= 1'b0;
            dlyCnt_r[g] <= 10'h000;
          end
          else if (raw_r[g] == alm_r[g])
            dlyCnt_r[g] <= 10'h000;
          else if ((raw_r[g] ? onDly_r[g] : offDly_r[g]) <= dlyCnt_r[g])
          begin
            alm_r[g] <= raw_r[g];
            dlyCnt_r[g] <= 10'h000;
          end
          else if (secTick_r)
            dlyCnt_r[g] <= dlyCnt_r[g] + 10'h001;
        end
      end
    end
  endgenerate

  // output assignment; heater alarm owns aux 1 until assigned to alarm 1
  always @*
  begin
    auxNxt = alm_r;
    if (heaterVariant && !assign1)
      auxNxt[0] = heatSync_r[1];
  end

  // events: rising edge of each aux output, and each raw alarm still waiting for its alarm (level, not edge)
  wire [3:0] evt = {auxNxt & ~auxOut, raw_r & ~alm_r};

  // axi write handling and register writes
  wire [7:0] wa = haveA_r ? wAddr_r : s_axi_awaddr;
  wire [31:0] wd = haveD_r ? wData_r : s_axi_wdata;
  wire [3:0] ws = haveD_r ? wStrb_r : s_axi_wstrb;
  wire [7:0] wRel = wa - `PAE_ADDR_CH0;
  wire [1:0] wIdx = wRel[5:4];
  wire [1:0] wFld = wa[3:2];
  wire wMapped = (wa == `PAE_ADDR_CTRL) || (wa == `PAE_ADDR_SP) ||
    (wa == `PAE_ADDR_STAT) || (wa == `PAE_ADDR_MASK) ||
    (wa == `PAE_ADDR_SCALE) || (wa == `PAE_ADDR_PV) || isChan(wa);
  wire [31:0] typeW = rmw({27'h000_0000, chType_r[wIdx[0]]}, wd, ws);
  wire typeOk = (typeW[4:0] <= `PAE_TYPE_MAX) &&
    (typeW[4:0] != `PAE_TYPE_LBA || wIdx[0] == 1'b0);
  wire [31:0] dlyW = rmw({6'h00, offDly_r[wIdx[0]], 6'h00, onDly_r[wIdx[0]]}, wd, ws);
  wire [31:0] spW = rmw({16'h0000, setPoint_r}, wd, ws);
  wire [31:0] maskW = rmw({28'h000_0000, mask_r}, wd, ws);
  wire [31:0] hiW = rmw({16'h0000, chHi_r[wIdx[0]]}, wd, ws);
  wire [31:0] loW = rmw({16'h0000, chLo_r[wIdx[0]]}, wd, ws);
  integer i;

  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PAE_RESP_OKAY;
      haveA_r <= 1'b0;
      haveD_r <= 1'b0;
      wAddr_r <= 8'h00;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      ctrl_r <= `PAE_CTRL_RESET;
      scale_r <= `PAE_SCALE_RESET;
      setPoint_r <= 16'h0000;
      stat_r <= 4'h0;
      mask_r <= 4'h0;
      irq <= 1'b0;
      auxOut <= 2'b00;
      for (i = 0; i < NCH; i = i + 1)
      begin
        chType_r[i] <= `PAE_TYPE_DEFAULT;
        chHi_r[i] <= 16'h0000;
        chLo_r[i] <= 16'h0000;
        onDly_r[i] <= 10'h000;
        offDly_r[i] <= 10'h000;
      end
    end
    else
    begin
      auxOut <= auxNxt;
      irq <= |(stat_r & mask_r);
      s_axi_awready <= !haveA_r && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
      s_axi_wready <= !haveD_r && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        haveA_r <= 1'b1;
        wAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        haveD_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // status bits: set beats clear
      stat_r <= (stat_r & ~((haveA_r && haveD_r && wAddr_r == `PAE_ADDR_STAT) ?
        wData_r[3:0] & {4{wStrb_r[0]}} : 4'h0)) | evt;
      if (haveA_r && haveD_r && !s_axi_bvalid)
      begin
        haveA_r <= 1'b0;
        haveD_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wMapped ? `PAE_RESP_OKAY : `PAE_RESP_SLVERR;
        if (wa == `PAE_ADDR_CTRL)
          ctrl_r <= rmw(ctrl_r, wd, ws);
        if (wa == `PAE_ADDR_SP)
          setPoint_r <= spW[15:0];
        if (wa == `PAE_ADDR_MASK)
          mask_r <= maskW[3:0];
        if (wa == `PAE_ADDR_SCALE)
          scale_r <= rmw(scale_r, wd, ws);
        if (isChan(wa))
          case (wFld)
            `PAE_CH_TYPE: if (typeOk) chType_r[wIdx[0]] <= typeW[4:0];
            `PAE_CH_HI: chHi_r[wIdx[0]] <= hiW[15:0];
            `PAE_CH_LO: chLo_r[wIdx[0]] <= loW[15:0];
            default:
            begin
              onDly_r[wIdx[0]] <= (dlyW[9:0] > `PAE_DLY_MAX) ? `PAE_DLY_MAX : dlyW[9:0];
              offDly_r[wIdx[0]] <= (dlyW[25:16] > `PAE_DLY_MAX) ? `PAE_DLY_MAX : dlyW[25:16];
            end
          endcase
      end
    end
  end

  // axi read
  wire [7:0] rRel = s_axi_araddr - `PAE_ADDR_CH0;
  wire [1:0] rIdx = rRel[5:4];
  reg [31:0] rNxt;
  reg rOk;
  always @*
  begin
    rOk = 1'b1;
    rNxt = 32'h0000_0000;
    if (s_axi_araddr == `PAE_ADDR_CTRL)
      rNxt = ctrl_r;
    else if (s_axi_araddr == `PAE_ADDR_SP)
      rNxt = {{16{setPoint_r[15]}}, setPoint_r};
    else if (s_axi_araddr == `PAE_ADDR_STAT)
      rNxt = {26'h000_0000, auxOut, stat_r};
    else if (s_axi_araddr == `PAE_ADDR_MASK)
      rNxt = {28'h000_0000, mask_r};
    else if (s_axi_araddr == `PAE_ADDR_PV)
      rNxt = {{16{pv_r[15]}}, pv_r};
    else if (s_axi_araddr == `PAE_ADDR_SCALE)
      rNxt = scale_r;
    else if (isChan(s_axi_araddr))
      case (s_axi_araddr[3:2])
        `PAE_CH_TYPE: rNxt = {27'h000_0000, chType_r[rIdx[0]]};
        `PAE_CH_HI: rNxt = {{16{chHi_r[rIdx[0]][15]}}, chHi_r[rIdx[0]]};
        `PAE_CH_LO: rNxt = {{16{chLo_r[rIdx[0]][15]}}, chLo_r[rIdx[0]]};
        default: rNxt = {6'h00, offDly_r[rIdx[0]], 6'h00, onDly_r[rIdx[0]]};
      endcase
    else
      rOk = 1'b0;
  end

  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PAE_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rNxt;
        s_axi_rresp <= rOk ? `PAE_RESP_OKAY : `PAE_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// *** pae_conv_model.sv ***
// converter model feeding raw samples into the alarm evaluator
`timescale 1ns/100ps
module pae_conv_model
  (
  // clock
  input logic mclk,
  // sample side
  output logic [15:0] rawSample,
  output logic rawValid
  );
  initial
  begin
    rawSample = 16'h0000;
    rawValid = 1'b0;
  end
  // data inverts outside the strobe so a stale code never passes for a fresh one
  task send(input logic [15:0] v);
    @(posedge mclk);
    rawSample <= v;
    rawValid <= 1'b1;
    @(posedge mclk);
    rawSample <= ~v;
    rawValid <= 1'b0;
  endtask
endmodule

// *** pae_alarm_evaluator_properties.sv ***
// assertions on the alarm evaluator ports
`timescale 1ns/100ps
module pae_alarm_evaluator_properties
  #(parameter SEC_CYCLES = 50000000)
  (
  // clock and reset
  input logic mclk,
  input logic sys_rst,
  // bus answers
  input logic s_axi_awready,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rready,
  // outputs
  input logic [1:0] auxOut,
  input logic irq
  );
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> auxOut == 2'b00 && !irq)
    else $error("outputs active after reset");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than a cycle");
  a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready longer than a cycle");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_b_code: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00 || s_axi_bresp == 2'b10)
    else $error("bad write answer code");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_w_latency: assert property (s_axi_awready && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  a_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
endmodule
bind pae_alarm_evaluator pae_alarm_evaluator_properties #(.SEC_CYCLES(SEC_CYCLES)) i_props (
  .mclk, .sys_rst, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .s_axi_rready,
  .auxOut, .irq);

// *** pae_alarm_evaluator_test.sv ***
// self-checking bench for the alarm evaluator
`timescale 1ns/100ps
module pae_alarm_evaluator_test;
  logic mclk = 1'b0, sys_rst = 1'b1, heaterAlarmIn = 1'b0;
  logic [15:0] rawSample;
  logic rawValid;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, auxOut, rs;
  logic [31:0] s_axi_rdata, rd;
  int num_errors = 0, num_checks = 0, cyc = 0;
  int tbl[7] = '{0, 1, 2, 3, 4, 8, 9};
  int stb[5] = '{5, 6, 7, 10, 11};
  always #10 mclk = ~mclk;
  pae_alarm_evaluator #(.SEC_CYCLES(10)) i_pae_alarm_evaluator (.mclk, .sys_rst, .rawSample,
    .rawValid, .heaterAlarmIn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .auxOut, .irq);
  pae_conv_model i_pae_conv_model (.mclk, .rawSample, .rawValid);
  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      $display("[ERR] %0t timeout", $time);
      tally_and_finish;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // scaling rounding is left open, so a small window is allowed
  task chkNear(input logic signed [15:0] got, input int exp);
    num_checks++;
    if ((got >= exp - 3 && got <= exp + 3) !== 1'b1)
    begin
      num_errors++;
      $display("[ERR] %0t pv %0d exp %0d", $time, got, exp);
    end
  endtask
  task rst;
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task axr(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    axr(a);
    chk(rd, e);
  endtask
  task setCh(input int ch, input int t, input int hi, input int lo, input logic [31:0] dly);
    logic [7:0] b;
    b = ch ? 8'h30 : 8'h20;
    axw(b, t);
    axw(b + 8'h04, hi);
    axw(b + 8'h08, lo);
    axw(b + 8'h0C, dly);
  endtask
  // raw zero reads as scale low, so the low bound sets the value exactly
  task setPv(input int v);
    axw(8'h14, {16'h270F, v[15:0]});
    i_pae_conv_model.send(16'h0000);
    repeat (8) @(posedge mclk);
  endtask
  task waitAux(input int ch, input logic v, input int n);
    for (int k = 0; k < n && auxOut[ch] !== v; k++)
      @(posedge mclk);
    chk(auxOut[ch], v);
  endtask
  function automatic logic alm(int t, int pv, int sp, int hi, int lo);
    int b;
    b = (t >= 5 && t <= 7) ? t - 4 : (t == 10 || t == 11) ? t - 2 : t;
    case (b)
      1: return pv > sp + hi || pv < sp - lo;
      2: return pv >= sp + hi;
      3: return pv <= sp - hi;
      4: return pv >= sp - lo && pv <= sp + hi;
      8: return pv > hi;
      9: return pv < hi;
      default: return 1'b0;
    endcase
  endfunction
  function automatic int pvx(int code, int raw, int lo, int hi);
    int z;
    z = (code == 25 || code == 27) ? 13107 : 0;
    if (raw <= z)
      return lo;
    return lo + (raw - z) * (hi - lo) / (65535 - z);
  endfunction
  initial
  begin
    int t, ch, pv, pf, sp, hi, lo, e;
    e = $urandom(32'hA317_1FFC);
    rst;
    rchk(8'h00, 32'h0000_0019);
    rchk(8'h14, 32'h270F_F831);
    rchk(8'h30, 32'h0000_0002);
    axw(8'hFC, 32'h0000_0001);
    chk(rs, 2'b10);
    axr(8'hFC);
    chk(rs, 2'b10);
    axw(8'h30, 32'h0000_000C);
    rchk(8'h30, 32'h0000_0002);
    axw(8'h20, 32'h0000_000C);
    rchk(8'h20, 32'h0000_000C);
    axw(8'h20, 32'h0000_0012);
    rchk(8'h20, 32'h0000_000C);
    axw(8'h2C, 32'h03FF_03FF);
    rchk(8'h2C, 32'h03E7_03E7);
    axw(8'h00, 32'h0000_0319);
    rchk(8'h00, 32'h0000_0319);
    for (t = 25; t <= 29; t++)
    begin
      lo = $urandom_range(2000) - 1999;
      hi = lo + 100 + $urandom_range(8000);
      e = $urandom_range(65535);
      axw(8'h00, t);
      axw(8'h14, {hi[15:0], lo[15:0]});
      i_pae_conv_model.send(e[15:0]);
      repeat (4) @(posedge mclk);
      axr(8'h10);
      chkNear(rd[15:0], pvx(t, e, lo, hi));
    end
    axw(8'h00, 32'h0000_0019);
    $display("registers and scaling done");
    for (int i = 0; i < 44; i++)
    begin
      ch = i < 4 ? 0 : $urandom_range(1);
      t = i < 4 ? tbl[i + 2] : tbl[$urandom_range(6)];
      sp = i < 4 ? 0 : $urandom_range(400) - 200;
      hi = i < 4 ? 300 : $urandom_range(450) + 50;
      lo = $urandom_range(450) + 50;
      pv = i < 4 ? (t == 3 ? -300 : 300) : $urandom_range(2000) - 1000;
      if (t != 8 && t != 9 && (pv == sp + hi || pv == sp - lo)) pv++;
      setCh(ch, t, hi, lo, 0);
      axw(8'h04, sp);
      setPv(pv);
      chk(auxOut[ch], alm(t, pv, sp, hi, lo));
    end
    $display("alarm types done");
    setCh(0, 0, 0, 0, 0);
    axw(8'h00, 32'h0000_1019);
    heaterAlarmIn <= 1'b1;
    waitAux(0, 1'b1, 10);
    axw(8'h00, 32'h0000_3019);
    waitAux(0, 1'b0, 10);
    heaterAlarmIn <= 1'b0;
    axw(8'h00, 32'h0000_0019);
    setCh(0, 8, 0, 0, 32'h0002_0003);
    setPv(500);
    repeat (8) @(posedge mclk);
    chk(auxOut[0], 1'b0);
    waitAux(0, 1'b1, 30);
    setPv(-500);
    chk(auxOut[0], 1'b1);
    waitAux(0, 1'b0, 30);
    $display("heater and delays done");
    setCh(0, 8, 0, 0, 0);
    setCh(1, 0, 0, 0, 0);
    axw(8'h08, 32'h0000_000F);
    axw(8'h0C, 32'h0000_0000);
    setPv(500);
    chk(irq, 1'b0);
    rchk(8'h08, 32'h0000_0015);
    axw(8'h0C, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b1);
    axw(8'h08, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b0);
    $display("interrupt done");
    for (int i = 0; i < 5; i++)
    begin
      t = stb[i];
      rst;
      setCh(0, t, 100, 100, 0);
      pv = alm(t, 500, 0, 100, 100) ? 500 : -500;
      pf = alm(t, 0, 0, 100, 100) ? -pv : 0;
      setPv(pv);
      chk(auxOut[0], 1'b0);
      setPv(pf);
      chk(auxOut[0], 1'b0);
      setPv(pv);
      chk(auxOut[0], 1'b1);
    end
    $display("standby done");
    tally_and_finish;
  end
endmodule
